/* File: rtl/wfg_pkg.sv */
// Purpose: shared constants for the waveform generator control block
// Assumes: AXI4-Lite register access, 100 MHz reference clock
// Notes: registers are 8 bits wide in the low byte of each word
// Operation
// - mode field picks one of six modes
// - load bit moves buffered dead bands, self-clears
// - polarity bit set inverts its output
// - rise dead band is six bits, top zero
// - fall dead band is six bits, top zero
// - shutdown bit set by active selected source
// - shutdown writable while disabled, forces overrides
// - overrides hold until next input rising edge
// - restart bit picks automatic or software restart
// - b/d override field sets shutdown level
// - a/c override field sets shutdown level
// - polarity alters only the inactive override level, code 0
// - software clear only with no active source
// - auto restart clears when sources go low
// - source select bits enable six trip inputs
// - override levels programmed, reset level is tri-state
// - setting auto restart while idle restarts
// - dead band counts clocks up to value
// - buffered load at falling edge when enabled
package wfg_pkg;
    // register bus
    localparam int ADDR_W = 5;
    localparam logic [4:0] OFS_CTRL0 = 5'h00;
    localparam logic [4:0] OFS_CTRL1 = 5'h04;
    localparam logic [4:0] OFS_RISE = 5'h08;
    localparam logic [4:0] OFS_FALL = 5'h0c;
    localparam logic [4:0] OFS_SDCTL = 5'h10;
    localparam logic [4:0] OFS_SDSEL = 5'h14;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // field positions
    localparam int EN_BIT = 7;
    localparam int LD_BIT = 6;
    localparam int IN_BIT = 5;
    localparam int SD_BIT = 7;
    localparam int REN_BIT = 6;
    localparam int OVERRIDE_LEVEL_BD_LO = 4;
    localparam int OVERRIDE_LEVEL_AC_LO = 2;
    // reset values
    localparam logic [1:0] OVR_RESET = 2'h1;
    localparam logic [5:0] DB_RESET = 6'h00;
    // mode codes
    localparam logic [2:0] MODE_ASTEER = 3'h0;
    localparam logic [2:0] MODE_SSTEER = 3'h1;
    localparam logic [2:0] MODE_FWD = 3'h2;
    localparam logic [2:0] MODE_REV = 3'h3;
    localparam logic [2:0] MODE_HALF = 3'h4;
    localparam logic [2:0] MODE_PUSH = 3'h5;
    // override level codes
    localparam logic [1:0] OVR_HIGH = 2'h3;
    localparam logic [1:0] OVR_LOW = 2'h2;
    localparam logic [1:0] OVR_TRI = 2'h1;
endpackage

/* File: rtl/wfg_deadband.sv */
// Purpose: one dead-band delay unit for a leading edge
// Assumes: request is a same-clock level
// Notes: output rises after counting up to the value, falls at once
`timescale 1ns/1ns
module wfg_deadband #(
    parameter int DB_W = 6
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_req,
    input wire logic [DB_W-1:0] i_count,
    output logic o_act
);
    logic [DB_W-1:0] cnt; // clocks counted since request
    logic [DB_W-1:0] next_cnt;
    logic next_act;

    initial
    begin
        if (DB_W < 1) $error("dead band width must be at least one");
    end

    // count from zero up to the programmed value, then go active
    always_comb
    begin
        next_cnt = cnt;
        next_act = o_act;
        if (!i_req)
        begin
            next_cnt = '0;
            next_act = 1'b0;
        end
        else if (!o_act)
        begin
            if (cnt == i_count)
                next_act = 1'b1;
            else
                next_cnt = cnt + 1'b1;
        end
    end

    // registers
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt <= '0;
            o_act <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            o_act <= next_act;
        end
    end

    db_done_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_req && !o_act && cnt == i_count) |=> o_act)
        else $error("dead band did not end at count");
    db_drop_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !i_req |=> !o_act && cnt == '0)
        else $error("dead band output stayed without request");
endmodule

/* File: rtl/wfg_ctrl.sv */
// Purpose: mode, dead-band and shutdown control of a four-output waveform generator
// Assumes: wave and trip inputs are asynchronous levels, trip high means active
// Notes: registers on AXI4-Lite, outputs a..d on bits 0..3
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
module wfg_ctrl (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_wave_in,
    input wire logic i_trip_input_pin,
    input wire logic i_trip_cmp1,
    input wire logic i_trip_cmp2,
    input wire logic i_trip_tmr2,
    input wire logic i_trip_tmr4,
    input wire logic i_trip_tmr6,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [wfg_pkg::ADDR_W-1:0] i_s_axi_awaddr,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    output logic [1:0] o_s_axi_bresp,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    input wire logic [wfg_pkg::ADDR_W-1:0] i_s_axi_araddr,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output logic [3:0] o_out,
    output logic [3:0] o_out_oe
);
    // reset release and input synchronisers
    logic rst_q1;
    logic rst_n; // released copy of reset
    logic [6:0] sync1; // first stage, read only by sync2
    logic [6:0] sync2;
    logic in_s; // synchronised waveform input
    logic [5:0] trip_s; // {tmr6, tmr4, tmr2, cmp2, cmp1, pin}

    // bus state
    logic aw_have, next_aw_have;
    logic [4:0] aw_addr, next_aw_addr;
    logic w_have, next_w_have;
    logic [7:0] w_data, next_w_data;
    logic w_strb0, next_w_strb0;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic wr_fire; // both halves of a write are held
    logic wr_en; // register write this cycle
    logic sd_wr; // write to shutdown control

    // register state
    logic en, next_en;
    logic ld, next_ld;
    logic [2:0] mode, next_mode;
    logic [3:0] pol, next_pol;
    logic [5:0] dbr_buf, next_dbr_buf; // software view
    logic [5:0] dbf_buf, next_dbf_buf;
    logic [5:0] dbr_act, next_dbr_act; // counts in use
    logic [5:0] dbf_act, next_dbf_act;
    logic sd, next_sd;
    logic ren, next_ren;
    logic [1:0] override_level_bd, next_override_level_bd;
    logic [1:0] override_level_ac, next_override_level_ac;
    logic [5:0] sel, next_sel;
    logic trip_act; // any selected source active

    // waveform state
    logic in_d, next_in_d;
    logic in_rise, in_fall;
    logic pp, next_pp; // push-pull phase
    logic hold, next_hold; // overrides held after shutdown
    logic ovr; // overrides in force
    logic req_r, req_f; // dead band requests
    logic db_r, db_f; // delayed leading edges
    logic [3:0] raw; // active levels before polarity
    logic [3:0] next_out, next_oe;
    logic [1:0] lvl;

    // test whether an address is a register
    function automatic logic hit(input logic [4:0] a);
        hit = (a == wfg_pkg::OFS_CTRL0) || (a == wfg_pkg::OFS_CTRL1) || (a == wfg_pkg::OFS_RISE) ||
            (a == wfg_pkg::OFS_FALL) || (a == wfg_pkg::OFS_SDCTL) || (a == wfg_pkg::OFS_SDSEL);
    endfunction

    // read data for one address
    function automatic logic [7:0] rd_byte(input logic [4:0] a);
        case (a)
            wfg_pkg::OFS_CTRL0: rd_byte = {en, ld, 3'h0, mode};
            wfg_pkg::OFS_CTRL1: rd_byte = {2'h0, in_s, 1'h0, pol};
            wfg_pkg::OFS_RISE: rd_byte = {2'h0, dbr_buf};
            wfg_pkg::OFS_FALL: rd_byte = {2'h0, dbf_buf};
            wfg_pkg::OFS_SDCTL: rd_byte = {sd, ren, override_level_bd, override_level_ac, 2'h0};
            wfg_pkg::OFS_SDSEL: rd_byte = {1'h1, sel[5:3], 1'h1, sel[2:0]};
            default: rd_byte = 8'h00;
        endcase
    endfunction

    // reset release
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rst_q1 <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_q1 <= 1'b1;
            rst_n <= rst_q1;
        end
    end

    // two-stage synchronisers for pins
    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1 <= 7'h00;
            sync2 <= 7'h00;
        end
        else
        begin
            sync1 <= {i_wave_in, i_trip_tmr6, i_trip_tmr4, i_trip_tmr2, i_trip_cmp2, i_trip_cmp1,
                i_trip_input_pin};
            sync2 <= sync1;
        end
    end

    assign in_s = sync2[6];
    assign trip_s = sync2[5:0];
    assign trip_act = |(trip_s & sel);
    assign wr_fire = aw_have && w_have && !o_s_axi_bvalid;
    assign wr_en = wr_fire && w_strb0 && hit(aw_addr);
    assign sd_wr = wr_en && (aw_addr == wfg_pkg::OFS_SDCTL);

    // bus slave: collect address and data, answer, read
    always_comb
    begin
        next_aw_have = aw_have;
        next_aw_addr = aw_addr;
        next_w_have = w_have;
        next_w_data = w_data;
        next_w_strb0 = w_strb0;
        next_bvalid = o_s_axi_bvalid;
        next_bresp = o_s_axi_bresp;
        next_rvalid = o_s_axi_rvalid;
        next_rdata = o_s_axi_rdata;
        next_rresp = o_s_axi_rresp;
        if (i_s_axi_awvalid && o_s_axi_awready)
        begin
            next_aw_have = 1'b1;
            next_aw_addr = i_s_axi_awaddr;
        end
        if (i_s_axi_wvalid && o_s_axi_wready)
        begin
            next_w_have = 1'b1;
            next_w_data = i_s_axi_wdata[7:0];
            next_w_strb0 = i_s_axi_wstrb[0];
        end
        if (wr_fire)
        begin
            // unmapped words answer slave error
            next_aw_have = 1'b0;
            next_w_have = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = hit(aw_addr) ? wfg_pkg::RESP_OKAY : wfg_pkg::RESP_SLVERR;
        end
        else if (o_s_axi_bvalid && i_s_axi_bready)
            next_bvalid = 1'b0;
        if (i_s_axi_arvalid && o_s_axi_arready)
        begin
            next_rvalid = 1'b1;
            next_rdata = {24'h000000, rd_byte(i_s_axi_araddr)};
            next_rresp = hit(i_s_axi_araddr) ? wfg_pkg::RESP_OKAY : wfg_pkg::RESP_SLVERR;
        end
        else if (o_s_axi_rvalid && i_s_axi_rready)
            next_rvalid = 1'b0;
        next_awready = !next_aw_have && !next_bvalid;
        next_wready = !next_w_have && !next_bvalid;
        next_arready = !next_rvalid;
    end

    // bus registers
    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_have <= 1'b0;
            aw_addr <= 5'h00;
            w_have <= 1'b0;
            w_data <= 8'h00;
            w_strb0 <= 1'b0;
            o_s_axi_awready <= 1'b0;
            o_s_axi_wready <= 1'b0;
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp <= 2'h0;
            o_s_axi_arready <= 1'b0;
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata <= 32'h00000000;
            o_s_axi_rresp <= 2'h0;
        end
        else
        begin
            aw_have <= next_aw_have;
            aw_addr <= next_aw_addr;
            w_have <= next_w_have;
            w_data <= next_w_data;
            w_strb0 <= next_w_strb0;
            o_s_axi_awready <= next_awready;
            o_s_axi_wready <= next_wready;
            o_s_axi_bvalid <= next_bvalid;
            o_s_axi_bresp <= next_bresp;
            o_s_axi_arready <= next_arready;
            o_s_axi_rvalid <= next_rvalid;
            o_s_axi_rdata <= next_rdata;
            o_s_axi_rresp <= next_rresp;
        end
    end

    // control registers, buffered dead bands, shutdown flag
    always_comb
    begin
        next_en = en;
        next_ld = ld;
        next_mode = mode;
        next_pol = pol;
        next_dbr_buf = dbr_buf;
        next_dbf_buf = dbf_buf;
        next_dbr_act = dbr_act;
        next_dbf_act = dbf_act;
        next_sd = sd;
        next_ren = ren;
        next_override_level_bd = override_level_bd;
        next_override_level_ac = override_level_ac;
        next_sel = sel;
        // buffered counts move at the falling input edge
        if (ld && in_fall)
        begin
            next_dbr_act = dbr_buf;
            next_dbf_act = dbf_buf;
            next_ld = 1'b0;
        end
        // automatic restart once no source is active
        if (ren && !trip_act)
            next_sd = 1'b0;
        if (wr_en)
        begin
            case (aw_addr)
                wfg_pkg::OFS_CTRL0:
                begin
                    next_en = w_data[wfg_pkg::EN_BIT];
                    next_mode = w_data[2:0];
                    // load request only counts once already enabled
                    if (en && w_data[wfg_pkg::LD_BIT])
                        next_ld = 1'b1;
                end
                wfg_pkg::OFS_CTRL1: next_pol = w_data[3:0];
                wfg_pkg::OFS_RISE:
                begin
                    next_dbr_buf = w_data[5:0];
                    if (!en)
                        next_dbr_act = w_data[5:0];
                end
                wfg_pkg::OFS_FALL:
                begin
                    next_dbf_buf = w_data[5:0];
                    if (!en)
                        next_dbf_act = w_data[5:0];
                end
                wfg_pkg::OFS_SDCTL:
                begin
                    next_ren = w_data[wfg_pkg::REN_BIT];
                    next_override_level_bd = w_data[wfg_pkg::OVERRIDE_LEVEL_BD_LO +: 2];
                    next_override_level_ac = w_data[wfg_pkg::OVERRIDE_LEVEL_AC_LO +: 2];
                    if (w_data[wfg_pkg::SD_BIT])
                        next_sd = 1'b1;
                    else if (!trip_act)
                        next_sd = 1'b0;
                end
                wfg_pkg::OFS_SDSEL: next_sel = {w_data[6:4], w_data[2:0]};
                default: next_sel = sel;
            endcase
        end
        if (!next_en)
            next_ld = 1'b0;
        // an active source always wins over any clear
        if (trip_act)
            next_sd = 1'b1;
    end

    // register file
    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            en <= 1'b0;
            ld <= 1'b0;
            mode <= wfg_pkg::MODE_ASTEER;
            pol <= 4'h0;
            dbr_buf <= wfg_pkg::DB_RESET;
            dbf_buf <= wfg_pkg::DB_RESET;
            dbr_act <= wfg_pkg::DB_RESET;
            dbf_act <= wfg_pkg::DB_RESET;
            sd <= 1'b0;
            ren <= 1'b0;
            override_level_bd <= wfg_pkg::OVR_RESET;
            override_level_ac <= wfg_pkg::OVR_RESET;
            sel <= 6'h00;
        end
        else
        begin
            en <= next_en;
            ld <= next_ld;
            mode <= next_mode;
            pol <= next_pol;
            dbr_buf <= next_dbr_buf;
            dbf_buf <= next_dbf_buf;
            dbr_act <= next_dbr_act;
            dbf_act <= next_dbf_act;
            sd <= next_sd;
            ren <= next_ren;
            override_level_bd <= next_override_level_bd;
            override_level_ac <= next_override_level_ac;
            sel <= next_sel;
        end
    end

    // rising and falling edge dead-band units
    wfg_deadband #(.DB_W(6)) u_db_rise (
        .i_clk(i_ref_clk),
        .i_rst_n(rst_n),
        .i_req(req_r),
        .i_count(dbr_act),
        .o_act(db_r)
    );
    wfg_deadband #(.DB_W(6)) u_db_fall (
        .i_clk(i_ref_clk),
        .i_rst_n(rst_n),
        .i_req(req_f),
        .i_count(dbf_act),
        .o_act(db_f)
    );

    assign in_rise = in_s && !in_d;
    assign in_fall = !in_s && in_d;
    assign ovr = sd || hold;

    // output waveform per mode, polarity and overrides
    always_comb
    begin
        next_in_d = in_s;
        next_pp = pp ^ in_rise;
        // overrides stay until the first rising edge after clear
        next_hold = sd || (hold && !in_rise);
        req_r = 1'b0;
        req_f = 1'b0;
        raw = 4'h0;
        case (mode)
            wfg_pkg::MODE_ASTEER, wfg_pkg::MODE_SSTEER: raw = {4{in_s}};
            wfg_pkg::MODE_FWD:
            begin
                req_f = in_s;
                raw = {db_f, 2'h0, 1'b1};
            end
            wfg_pkg::MODE_REV:
            begin
                req_r = in_s;
                raw = {1'b0, 1'b1, db_r, 1'b0};
            end
            wfg_pkg::MODE_HALF:
            begin
                req_r = in_s;
                req_f = !in_s;
                raw = {db_f, db_r, db_f, db_r};
            end
            wfg_pkg::MODE_PUSH: raw = {in_s && !pp, in_s && pp, in_s && !pp, in_s && pp};
            default: raw = 4'h0; // reserved codes stay inactive
        endcase
        next_out = 4'h0;
        next_oe = 4'h0;
        lvl = override_level_ac;
        for (int i = 0; i < 4; i++)
        begin
            lvl = i[0] ? override_level_bd : override_level_ac;
            if (ovr)
            begin
                // forced high, low and tri-state levels ignore polarity
                case (lvl)
                    wfg_pkg::OVR_HIGH:
                    begin
                        next_out[i] = 1'b1;
                        next_oe[i] = 1'b1;
                    end
                    wfg_pkg::OVR_LOW: next_oe[i] = 1'b1;
                    wfg_pkg::OVR_TRI: next_oe[i] = 1'b0;
                    default:
                    begin
                        next_out[i] = pol[i]; // inactive level with polarity
                        next_oe[i] = 1'b1;
                    end
                endcase
            end
            else
            begin
                next_out[i] = raw[i] ^ pol[i];
                next_oe[i] = en;
            end
        end
    end

    // waveform registers
    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            in_d <= 1'b0;
            pp <= 1'b0;
            hold <= 1'b0;
            o_out <= 4'h0;
            o_out_oe <= 4'h0;
        end
        else
        begin
            in_d <= next_in_d;
            pp <= next_pp;
            hold <= next_hold;
            o_out <= next_out;
            o_out_oe <= next_oe;
        end
    end

    sd_set_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n) trip_act |=> sd)
        else $error("active trip did not set shutdown");
    sw_clr_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        (sd_wr && !w_data[wfg_pkg::SD_BIT] && trip_act) |=> sd)
        else $error("shutdown cleared with source active");
    auto_clr_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        (sd && ren && !trip_act && !sd_wr) |=> !sd)
        else $error("auto restart did not clear shutdown");
    hold_edge_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        (!sd && hold && !in_rise && override_level_bd == wfg_pkg::OVR_HIGH)
        |=> ((override_level_bd == wfg_pkg::OVR_HIGH) |=> o_out[1] && o_out[3] && o_out_oe[1]))
        else $error("override released before rising edge");
    ovr_ac_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        (ovr && override_level_ac == wfg_pkg::OVR_HIGH) |=> o_out[0] && o_out[2] && o_out_oe[0])
        else $error("a/c override high not driven");
    ovr_bd_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        (ovr && override_level_bd == wfg_pkg::OVR_TRI) |=> !o_out_oe[1] && !o_out_oe[3])
        else $error("b/d override not tri-stated");
    ld_xfer_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        (ld && in_fall && !wr_en) |=> !ld && dbr_act == $past(dbr_buf) && dbf_act == $past(dbf_buf))
        else $error("buffered dead band not loaded");
    pol_steer_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        (!ovr && en && mode == wfg_pkg::MODE_ASTEER) |=> o_out[0] == ($past(in_s) ^ $past(pol[0])))
        else $error("steering polarity wrong");
    sel_one_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        (i_s_axi_arvalid && o_s_axi_arready && i_s_axi_araddr == wfg_pkg::OFS_SDSEL)
        |=> o_s_axi_rdata[7] && o_s_axi_rdata[3])
        else $error("unused select bits not one");
endmodule

/* File: dv/wfg_far_model.sv */
// Purpose: far side of the waveform generator: wave source, trip sources, output pins
// Assumes: bench commands change just after a rising edge
// Notes: an undriven pin shows the inverse of its last level, never a held value
`timescale 1ns/1ns
module wfg_far_model (
    input wire logic i_clk,
    input wire logic i_wave_cmd,
    input wire logic [5:0] i_trip_cmd,
    input wire logic [3:0] i_out,
    input wire logic [3:0] i_out_oe,
    output logic o_wave,
    output logic [5:0] o_trip,
    output logic [3:0] o_pin
);
    logic [3:0] last = 4'h0; // last driven pin levels
    // trip levels, one bit a source: pin, cmp1, cmp2, tmr2, tmr4, tmr6
    always_ff @(posedge i_clk)
    begin
        o_wave <= i_wave_cmd;
        o_trip <= i_trip_cmd;
        last <= (i_out & i_out_oe) | (last & ~i_out_oe);
    end
    // released pins float away from their last level
    assign o_pin = (i_out & i_out_oe) | (~last & ~i_out_oe);
endmodule

/* File: dv/complementary_waveform_control_bench.sv */
// Purpose: register and shutdown checks of the waveform generator control block
// Assumes: AXI4-Lite master tasks, 100 MHz clock
// Notes: outputs a..d on bits 0..3
`timescale 1ns/1ns
module complementary_waveform_control_bench;
    logic clk = 0, rst_b = 0, wave = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic [4:0] awa = 0, ara = 0;
    logic [31:0] wd = 0;
    logic [5:0] trip = 0;
    logic w_in, awr, wr_y, bv, arr, rv;
    logic [5:0] t_in;
    logic [1:0] bresp, rresp;
    logic [31:0] rdat;
    logic [3:0] outs, oe, pins;
    int err_total = 0, n_compared = 0;
    wfg_ctrl wfg_ctrl_inst (.i_ref_clk(clk), .i_rst_b(rst_b), .i_wave_in(w_in), .i_trip_input_pin(t_in[0]),
        .i_trip_cmp1(t_in[1]), .i_trip_cmp2(t_in[2]), .i_trip_tmr2(t_in[3]), .i_trip_tmr4(t_in[4]),
        .i_trip_tmr6(t_in[5]), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_awaddr(awa),
        .i_s_axi_wvalid(wv), .o_s_axi_wready(wr_y), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hf),
        .o_s_axi_bvalid(bv), .i_s_axi_bready(br), .o_s_axi_bresp(bresp), .i_s_axi_arvalid(arv),
        .o_s_axi_arready(arr), .i_s_axi_araddr(ara), .o_s_axi_rvalid(rv), .i_s_axi_rready(rr),
        .o_s_axi_rdata(rdat), .o_s_axi_rresp(rresp), .o_out(outs), .o_out_oe(oe));
    wfg_far_model wfg_far_model_inst (.i_clk(clk), .i_wave_cmd(wave), .i_trip_cmd(trip), .i_out(outs),
        .i_out_oe(oe), .o_wave(w_in), .o_trip(t_in), .o_pin(pins));
    // clock, 10 ns period
    initial
    begin
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e)
        begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic end_sim();
        $display("compared %0d, wrong %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // write: address and data together, each released when taken
    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        logic ad, dd;
        ad = 0;
        dd = 0;
        @(posedge clk);
        awv <= 1; awa <= a; wv <= 1; wd <= d; br <= 1;
        while (!(ad && dd))
        begin
            @(posedge clk);
            if (!ad && awr === 1'b1) begin ad = 1; awv <= 0; end
            if (!dd && wr_y === 1'b1) begin dd = 1; wv <= 0; end
        end
        do @(posedge clk); while (bv !== 1'b1);
        br <= 0;
        chk(bresp, er);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
        @(posedge clk);
        arv <= 1; ara <= a; rr <= 1;
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 0;
        do @(posedge clk); while (rv !== 1'b1);
        rr <= 0;
        chk(rdat, e);
        chk(rresp, er);
    endtask
    // watchdog far beyond the expected run length
    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        end_sim();
    end
    initial
    begin
        logic [7:0] rv_tab [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h14, 8'h88};
        repeat (5) @(posedge clk);
        rst_b <= 1;
        do @(posedge clk); while (awr !== 1'b1);
        for (int i = 0; i < 6; i++) rd(5'(i * 4), rv_tab[i]);
        rd(5'h18, 0, 2'h2);
        wr(5'h18, 32'hff, 2'h2);
        wr(5'h08, 32'hff); rd(5'h08, 32'h3f);
        wr(5'h0c, 32'hff); rd(5'h0c, 32'h3f);
        wr(5'h14, 32'h77); rd(5'h14, 32'hff);
        wr(5'h14, 32'h01);
        for (int m = 0; m < 6; m++) begin wr(5'h00, m); rd(5'h00, m); end
        $display("test registers done");
        wr(5'h04, 32'h0f); rd(5'h04, 32'h0f);
        wr(5'h10, 32'h9c); repeat (4) @(posedge clk); chk(oe, 4'h5);
        chk(outs, 4'h5); chk(pins, 4'hf);
        wr(5'h10, 32'hb8); repeat (4) @(posedge clk); chk(outs, 4'ha);
        chk(oe, 4'hf); rd(5'h10, 32'hb8);
        wr(5'h00, 32'hc4); rd(5'h00, 32'h84);
        wr(5'h04, 32'h00);
        trip <= 6'h01; repeat (8) @(posedge clk);
        wr(5'h10, 32'h38); rd(5'h10, 32'hb8);
        trip <= 6'h00; repeat (8) @(posedge clk);
        wr(5'h10, 32'h38); rd(5'h10, 32'h38);
        chk(outs, 4'ha);
        wave <= 1; repeat (30) @(posedge clk); chk(outs, 4'h0);
        repeat (70) @(posedge clk); chk(outs, 4'h5);
        $display("test shutdown done");
        wr(5'h00, 32'hc4); rd(5'h00, 32'hc4);
        wave <= 0; repeat (8) @(posedge clk); rd(5'h00, 32'h84);
        trip <= 6'h01; repeat (8) @(posedge clk); rd(5'h10, 32'hb8);
        wr(5'h10, 32'hf8); rd(5'h10, 32'hf8);
        trip <= 6'h00; repeat (8) @(posedge clk); rd(5'h10, 32'h78);
        wr(5'h10, 32'hb8); wr(5'h10, 32'hf8); repeat (4) @(posedge clk);
        rd(5'h10, 32'h78);
        $display("test restart done");
        wr(5'h04, 32'h01); wr(5'h00, 32'h80);
        wave <= 1; repeat (8) @(posedge clk); chk(outs, 4'he); chk(oe, 4'hf);
        wave <= 0; repeat (8) @(posedge clk); chk(outs, 4'h1);
        wr(5'h00, 32'h82); wave <= 1; repeat (30) @(posedge clk); chk(outs, 4'h0);
        repeat (50) @(posedge clk); chk(outs, 4'h8);
        wr(5'h0c, 32'h02); rd(5'h0c, 32'h02);
        wr(5'h00, 32'hc2); wave <= 0; repeat (8) @(posedge clk);
        wave <= 1; repeat (12) @(posedge clk); chk(outs, 4'h8);
        $display("test modes done");
        end_sim();
    end
endmodule
